/* src/dsts_pkg.sv */
// microcode_constant and types shared by the sector transfer sequencer
// ****************************************************************
// Overview of operation
// - write shifts each byte out bit 0 first, then loads next and bumps counter
// - write repeats load and shift until exactly 512 buffer bytes are sent
// - at counter maximum buffer-full rises and the 32-bit ECC is shifted out
// - after ECC stop ECC, hold write gate and encoder for 16 zeros, then drop gate
// - after write gate drops, go to CPU clock, clear counter, raise transfer request
// - CPU grants when sectors remain; the grant clears the transfer request
// - on request clear swap buffer, test ready bit, advance address, restart sector
// - ready bit seen after grant: set status ready, interrupt if enabled, go idle
// - read start selects servo clock; full buffer gives data late finish
// - empty buffer: drop read gate, wait splice, raise gate, clear ECC
// - count 88 servo ticks, clear counter, preset compare constant to 19 hex
// - datapath follows read clock; sequencer stalls until sync byte found
// - on sync found resume, enable ECC and assemble 512 read bytes
// - every eight bits write the assembled byte to buffer and bump counter
// - at buffer-full take in disk ECC, compare, clear counter, test error
// - ECC error: correction outcome on two lines, CPU clock, ready, interrupt, idle
// - no ECC error: drop read clock, CPU clock, raise transfer request
// - read grant clears request, then swap buffer, test ready, next or finish
// - write sends 120 zero gap bits and sync byte 19 hex before data
// ****************************************************************
package dsts_pkg;
  localparam logic [9:0] BUF_BYTES = 10'h200;
  localparam logic [7:0] BYTE_LAST = 8'h07;
  localparam logic [7:0] GAP_BITS = 8'h78;
  localparam logic [7:0] PAD_BITS = 8'h10;
  localparam logic [7:0] ECC_BITS = 8'h20;
  localparam logic [7:0] LOCK_TICKS = 8'h58;
  localparam logic [7:0] SPLICE_TICKS = 8'h28;
  localparam logic [7:0] GATE_TICKS = 8'h08;
  localparam logic [7:0] SYNC_BYTE = 8'h19;
  localparam logic [31:0] ECC_POLY = 32'h0040_0007;
  // register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  // control word fields
  localparam int B_CONTROLLER_READY_BIT = 0;
  localparam int B_IE = 1;
  localparam int B_READ = 2;
  // status word fields
  localparam int S_CONTROLLER_READY_BIT = 0;
  localparam int S_DLE = 1;
  localparam int S_CMPA = 2;
  localparam int S_STAT = 3;
  localparam int S_REQ = 5;
  localparam int S_BSEL = 6;
  localparam int S_BUSY = 7;
  // correction outcome reported on the two status lines
  localparam logic [1:0] CORR_UNFIXED = 2'h1;
  // pin synchroniser lanes
  localparam int P_SERVO = 0;
  localparam int P_RCLK = 1;
  localparam int P_RDAT = 2;
  localparam int P_DRDY = 3;
  localparam int P_NUM = 4;
  typedef enum logic [1:0] {
    CK_CPU,
    CK_SERVO,
    CK_READ
  } dsts_clk_e;
endpackage

/* src/dsts_sync.sv */
// two-flop synchronisers for the drive pins
`timescale 1ns/1ps
`default_nettype none
module dsts_sync
  import dsts_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic en, // clock enable
  input wire logic [P_NUM-1:0] d, // raw pins
  output logic [P_NUM-1:0] q // synchronised pins
);
  typedef struct packed {
    logic [P_NUM-1:0] s1;
    logic [P_NUM-1:0] s2;
  } dsts_sync_s;
  dsts_sync_s r_r, r_nxt;
  genvar i;
  generate
    for (i = 0; i < P_NUM; i++) begin : g_lane
      always_comb begin
        r_nxt.s1[i] = d[i];
        r_nxt.s2[i] = r_r.s1[i];
      end
    end
  endgenerate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= '0;
    end else if (en) begin
      r_r <= r_nxt;
    end
  end
  assign q = r_r.s2;
endmodule
`default_nettype wire

/* src/dsts_ecc.sv */
// serial 32-bit ECC generator and checker
`timescale 1ns/1ps
`default_nettype none
module dsts_ecc
  import dsts_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic en, // clock enable
  input wire logic clr, // clear remainder
  input wire logic feed, // absorb din
  input wire logic din, // serial data bit
  input wire logic shift, // shift remainder out
  output logic msb, // next ECC bit out
  output logic zero // remainder is zero
);
  typedef struct packed {
    logic [31:0] rem;
  } dsts_ecc_s;
  dsts_ecc_s r_r, r_nxt;
  logic fb;
  // feeding the stored ECC after the data leaves zero when they agree
  always_comb begin
    r_nxt = r_r;
    fb = r_r.rem[31] ^ din;
    if (clr) begin
      r_nxt.rem = '0;
    end else if (feed) begin
      r_nxt.rem = {r_r.rem[30:0], 1'b0} ^ (fb ? ECC_POLY : 32'h0);
    end else if (shift) begin
      r_nxt.rem = {r_r.rem[30:0], 1'b0};
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= '0;
    end else if (en) begin
      r_r <= r_nxt;
    end
  end
  assign msb = r_r.rem[31];
  assign zero = (r_r.rem == 32'h0);
endmodule
`default_nettype wire

/* src/dsts_seq.sv */
// sector data phase sequencer: write, read, transfer handshake
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module dsts_seq
  import dsts_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic en, // clock enable, freezes state when low
  input wire logic [3:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic transfer_grant, // CPU grant
  output logic port_transfer_request, // sector ready for CPU
  output logic bus_request_level5, // completion interrupt request
  input wire logic drive_servo_clock, // drive servo clock pin
  input wire logic drive_read_clock, // drive read clock pin
  input wire logic drive_read_data, // drive serial read data pin
  input wire logic drive_ready, // drive ready pin
  output logic read_gate, // read gate tag
  output logic write_gate, // write gate tag
  output logic write_encoder_enable, // serial encoder enable
  output logic drive_write_data, // serial write data
  output logic shift_out_bit, // shift register bit 0
  output logic [1:0] clock_select, // datapath clock source
  output logic sync_byte_found, // sync byte seen on read
  input wire logic buffer_full_in, // selected buffer holds a sector
  input wire logic [7:0] buf_rdata, // byte at buf_addr
  output logic buf_select, // 0 buffer A, 1 buffer B
  output logic [8:0] buf_addr, // buffer address counter
  output logic [7:0] buf_wdata, // byte to buffer
  output logic buf_we, // buffer write pulse
  output logic buffer_full_flag, // counter at maximum
  output logic [15:0] disk_address, // sector address
  output logic timer_restart, // function timer reset pulse
  output logic [1:0] ecc_status // correction outcome lines
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_CHK, ST_WLOOP, ST_WGAP, ST_WSYNC, ST_WDATA, ST_WECC,
    ST_WPAD, ST_SPLICE, ST_LOCK, ST_HUNT, ST_RDATA, ST_RECC, ST_RCHK,
    ST_RCORR, ST_XFER
  } dsts_st_e;
  typedef enum logic {
    NX_NEXT,
    NX_HOLD
  } dsts_nx_e;
  typedef struct packed {
    dsts_st_e st;
    logic nxt_pend;
    dsts_clk_e ck;
    logic rg;
    logic wg;
    logic enc;
    logic wdat;
    logic req;
    logic irq;
    logic controller_ready_bit;
    logic dle;
    logic cmpa;
    logic [1:0] stat;
    logic ie;
    logic controller_ready_bit_cmd;
    logic rdfn;
    logic bsel;
    logic [9:0] cnt;
    logic full;
    logic [7:0] bitc;
    logic [7:0] sr;
    logic [7:0] cst;
    logic syncf;
    logic we;
    logic [7:0] wd;
    logic [15:0] dadr;
    logic trst;
    logic [31:0] rdata;
    logic ps;
    logic pr;
  } dsts_seq_s;
  dsts_seq_s q_r, q_nxt;
  logic [P_NUM-1:0] pin;
  logic stick, rtick, rbit;
  logic ecc_clr, ecc_feed, ecc_din, ecc_shift, ecc_msb, ecc_zero;
  logic [7:0] rbyte;
  dsts_sync u_sync (
    .clk(clk),
    .rst(rst),
    .en(en),
    .d({drive_ready, drive_read_data, drive_read_clock, drive_servo_clock}),
    .q(pin)
  );
  dsts_ecc u_ecc (
    .clk(clk),
    .rst(rst),
    .en(en),
    .clr(ecc_clr),
    .feed(ecc_feed),
    .din(ecc_din),
    .shift(ecc_shift),
    .msb(ecc_msb),
    .zero(ecc_zero)
  );
  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.we = 1'b0;
    q_nxt.trst = 1'b0;
    q_nxt.rdata = 32'h0;
    q_nxt.ps = pin[P_SERVO];
    q_nxt.pr = pin[P_RCLK];
    stick = pin[P_SERVO] & ~q_r.ps;
    rtick = pin[P_RCLK] & ~q_r.pr;
    rbit = pin[P_RDAT];
    rbyte = {rbit, q_r.sr[7:1]};
    ecc_clr = 1'b0;
    ecc_feed = 1'b0;
    ecc_din = 1'b0;
    ecc_shift = 1'b0;
    if (q_r.we) begin
      q_nxt.cnt = q_r.cnt + 10'h1;
    end
    // ****************************************************************
    // register port
    // ****************************************************************
    if (reg_rd) begin
      case (reg_addr)
        OFF_CTRL: begin
          q_nxt.rdata[B_CONTROLLER_READY_BIT] = q_r.controller_ready_bit_cmd;
          q_nxt.rdata[B_IE] = q_r.ie;
          q_nxt.rdata[B_READ] = q_r.rdfn;
        end
        OFF_STAT: begin
          q_nxt.rdata[S_CONTROLLER_READY_BIT] = q_r.controller_ready_bit;
          q_nxt.rdata[S_DLE] = q_r.dle;
          q_nxt.rdata[S_CMPA] = q_r.cmpa;
          q_nxt.rdata[S_STAT+1:S_STAT] = q_r.stat;
          q_nxt.rdata[S_REQ] = q_r.req;
          q_nxt.rdata[S_BSEL] = q_r.bsel;
          q_nxt.rdata[S_BUSY] = (q_r.st != ST_IDLE);
        end
        default: q_nxt.rdata = 32'h0;
      endcase
    end
    if (reg_wr && reg_addr == OFF_CTRL) begin
      q_nxt.controller_ready_bit_cmd = reg_wdata[B_CONTROLLER_READY_BIT];
      q_nxt.ie = reg_wdata[B_IE];
      q_nxt.irq = 1'b0;
      // a control word with ready clear starts a function from idle
      if (q_r.st == ST_IDLE && !reg_wdata[B_CONTROLLER_READY_BIT]) begin
        q_nxt.rdfn = reg_wdata[B_READ];
        q_nxt.controller_ready_bit = 1'b0;
        q_nxt.dle = 1'b0;
        q_nxt.stat = 2'h0;
        q_nxt.st = ST_CHK;
      end
    end
    case (q_r.st)
      ST_IDLE: begin
        q_nxt.ck = CK_CPU;
      end
      ST_CHK: begin
        q_nxt.ck = CK_SERVO;
        q_nxt.bitc = 8'h0;
        // write needs a loaded buffer, read needs an empty one
        if (buffer_full_in == q_r.rdfn) begin
          q_nxt.cmpa = 1'b0;
          q_nxt.controller_ready_bit = 1'b1;
          q_nxt.dle = 1'b1;
          q_nxt.irq = q_r.ie;
          q_nxt.ck = CK_CPU;
          q_nxt.st = ST_IDLE;
        end else begin
          q_nxt.rg = 1'b0;
          q_nxt.st = q_r.rdfn ? ST_SPLICE : ST_WLOOP;
        end
      end
      ST_WLOOP: if (stick) begin
        q_nxt.bitc = q_r.bitc + 8'h1;
        if (q_r.bitc == GATE_TICKS - 8'h1) begin
          q_nxt.wg = 1'b1;
          q_nxt.sr = 8'h0;
          q_nxt.cnt = 10'h0;
          // the tick that raises the gate already carries the first gap zero
          q_nxt.wdat = 1'b0;
          q_nxt.bitc = 8'h1;
          q_nxt.st = ST_WGAP;
        end
      end
      ST_WGAP: if (stick) begin
        q_nxt.wdat = 1'b0;
        q_nxt.bitc = q_r.bitc + 8'h1;
        if (q_r.bitc == GAP_BITS - 8'h1) begin
          q_nxt.sr = SYNC_BYTE;
          q_nxt.enc = 1'b1;
          q_nxt.bitc = 8'h0;
          ecc_clr = 1'b1;
          q_nxt.st = ST_WSYNC;
        end
      end
      ST_WSYNC, ST_WDATA: if (stick) begin
        q_nxt.wdat = q_r.sr[0];
        q_nxt.sr = {1'b0, q_r.sr[7:1]};
        q_nxt.bitc = q_r.bitc + 8'h1;
        if (q_r.st == ST_WDATA) begin
          ecc_feed = 1'b1;
          ecc_din = q_r.sr[0];
        end
        if (q_r.bitc == BYTE_LAST) begin
          q_nxt.bitc = 8'h0;
          if (q_r.cnt == BUF_BYTES) begin
            q_nxt.st = ST_WECC;
          end else begin
            q_nxt.sr = buf_rdata;
            q_nxt.cnt = q_r.cnt + 10'h1;
            q_nxt.st = ST_WDATA;
          end
        end
      end
      ST_WECC: if (stick) begin
        q_nxt.wdat = ecc_msb;
        ecc_shift = 1'b1;
        q_nxt.bitc = q_r.bitc + 8'h1;
        if (q_r.bitc == ECC_BITS - 8'h1) begin
          q_nxt.bitc = 8'h0;
          q_nxt.st = ST_WPAD;
        end
      end
      ST_WPAD: if (stick) begin
        q_nxt.wdat = 1'b0;
        q_nxt.bitc = q_r.bitc + 8'h1;
        // gate drops one tick after the last zero so that bit keeps its full cell
        if (q_r.bitc == PAD_BITS) begin
          q_nxt.wg = 1'b0;
          q_nxt.enc = 1'b0;
          q_nxt.ck = CK_CPU;
          q_nxt.cnt = 10'h0;
          q_nxt.req = 1'b1;
          q_nxt.st = ST_XFER;
        end
      end
      ST_SPLICE: if (stick) begin
        q_nxt.bitc = q_r.bitc + 8'h1;
        if (q_r.bitc == SPLICE_TICKS - 8'h1) begin
          q_nxt.rg = 1'b1;
          ecc_clr = 1'b1;
          q_nxt.bitc = 8'h0;
          q_nxt.st = ST_LOCK;
        end
      end
      ST_LOCK: if (stick) begin
        q_nxt.bitc = q_r.bitc + 8'h1;
        if (q_r.bitc == LOCK_TICKS - 8'h1) begin
          q_nxt.cnt = 10'h0;
          q_nxt.cst = SYNC_BYTE;
          q_nxt.sr = 8'h0;
          q_nxt.bitc = 8'h0;
          q_nxt.ck = CK_READ;
          q_nxt.st = ST_HUNT;
        end
      end
      // sequencer holds here; only the window shifts on read clock
      ST_HUNT: if (rtick) begin
        q_nxt.sr = rbyte;
        if (rbyte == q_r.cst) begin
          q_nxt.syncf = 1'b1;
          q_nxt.st = ST_RDATA;
        end
      end
      ST_RDATA: begin
        if (q_r.we && q_r.cnt == BUF_BYTES - 10'h1) begin
          q_nxt.bitc = 8'h0;
          q_nxt.st = ST_RECC;
        end else if (rtick) begin
          q_nxt.sr = rbyte;
          ecc_feed = 1'b1;
          ecc_din = rbit;
          q_nxt.bitc = q_r.bitc + 8'h1;
          if (q_r.bitc == BYTE_LAST) begin
            q_nxt.bitc = 8'h0;
            q_nxt.wd = rbyte;
            q_nxt.we = 1'b1;
          end
        end
      end
      ST_RECC: if (rtick) begin
        ecc_feed = 1'b1;
        ecc_din = rbit;
        q_nxt.bitc = q_r.bitc + 8'h1;
        if (q_r.bitc == ECC_BITS - 8'h1) begin
          q_nxt.syncf = 1'b0;
          q_nxt.st = ST_RCHK;
        end
      end
      ST_RCHK: begin
        q_nxt.cnt = 10'h0;
        if (!ecc_zero) begin
          q_nxt.st = ST_RCORR;
        end else begin
          q_nxt.ck = CK_CPU;
          q_nxt.req = 1'b1;
          q_nxt.st = ST_XFER;
        end
      end
      // correction is not attempted here; outcome reports it uncorrected
      ST_RCORR: begin
        q_nxt.stat = CORR_UNFIXED;
        q_nxt.ck = CK_CPU;
        q_nxt.cnt = 10'h0;
        q_nxt.controller_ready_bit = 1'b1;
        q_nxt.irq = q_r.ie;
        q_nxt.st = ST_IDLE;
      end
      ST_XFER: begin
        if (q_r.req && transfer_grant) begin
          q_nxt.req = 1'b0;
          q_nxt.nxt_pend = NX_NEXT;
        end else if (!q_r.req) begin
          q_nxt.bsel = ~q_r.bsel;
          // controller-ready in the control word must precede the grant
          if (q_r.controller_ready_bit_cmd) begin
            q_nxt.controller_ready_bit = 1'b1;
            q_nxt.irq = q_r.ie;
            q_nxt.st = ST_IDLE;
          end else if (pin[P_DRDY]) begin
            q_nxt.dadr = q_r.dadr + 16'h1;
            q_nxt.trst = 1'b1;
            q_nxt.st = ST_CHK;
          end else begin
            q_nxt.controller_ready_bit = 1'b1;
            q_nxt.irq = q_r.ie;
            q_nxt.st = ST_IDLE;
          end
        end
      end
      default: q_nxt.st = ST_IDLE;
    endcase
    q_nxt.full = (q_nxt.cnt == BUF_BYTES);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
      q_r.st <= ST_IDLE;
      q_r.ck <= CK_CPU;
      q_r.nxt_pend <= NX_HOLD;
    end else if (en) begin
      q_r <= q_nxt;
    end
  end
  assign reg_rdata = q_r.rdata;
  assign port_transfer_request = q_r.req;
  assign bus_request_level5 = q_r.irq;
  assign read_gate = q_r.rg;
  assign write_gate = q_r.wg;
  assign write_encoder_enable = q_r.enc;
  assign drive_write_data = q_r.wdat;
  assign shift_out_bit = q_r.sr[0];
  assign clock_select = q_r.ck;
  assign sync_byte_found = q_r.syncf;
  assign buf_select = q_r.bsel;
  assign buf_addr = q_r.cnt[8:0];
  assign buf_wdata = q_r.wd;
  assign buf_we = q_r.we;
  assign buffer_full_flag = q_r.full;
  assign disk_address = q_r.dadr;
  assign timer_restart = q_r.trst;
  assign ecc_status = q_r.stat;
endmodule
`default_nettype wire

/* tb/dsts_chk.sv */
// assertion checker for the sector transfer sequencer
`timescale 1ns/1ps
`default_nettype none
module dsts_chk
  import dsts_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic transfer_grant, // cpu grant
  input wire logic port_transfer_request, // sector ready
  input wire logic bus_request_level5, // interrupt
  input wire logic read_gate, // read gate tag
  input wire logic write_gate, // write gate tag
  input wire logic drive_write_data, // serial write data
  input wire logic [1:0] clock_select, // datapath clock source
  input wire logic sync_byte_found, // sync byte seen
  input wire logic buf_select, // buffer choice
  input wire logic [8:0] buf_addr, // buffer counter
  input wire logic buf_we, // buffer write pulse
  input wire logic buffer_full_flag // counter at maximum
);
  // sixteen zero bits at 12 clocks a bit leave at least 192 quiet clocks
  localparam int ZERO_MIN = 150;
  logic [8:0] zc_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zc_r <= 9'h0;
    end else if (drive_write_data) begin
      zc_r <= 9'h0;
    end else if (zc_r != 9'h1ff) begin
      zc_r <= zc_r + 9'h1;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_grant;
    port_transfer_request && transfer_grant;
  endsequence
  sequence s_swap;
    !port_transfer_request ##[1:3] $changed(buf_select);
  endsequence
  property p_handshake;
    s_grant |=> s_swap;
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("grant did not drop request and swap buffer");
  property p_gap;
    $rose(write_gate) |-> (!drive_write_data) [*8];
  endproperty
  a_gap: assert property (p_gap)
    else $error("write gap not zero");
  property p_tail;
    $fell(write_gate) |-> zc_r >= ZERO_MIN;
  endproperty
  a_tail: assert property (p_tail)
    else $error("write gate dropped before trailing zeros");
  property p_wr_done;
    $fell(write_gate) |-> ##[1:40] (port_transfer_request && clock_select == 2'h0
      && buf_addr == 9'h0);
  endproperty
  a_wr_done: assert property (p_wr_done)
    else $error("no request after write");
  property p_bump;
    buf_we |=> (buf_addr == $past(buf_addr) + 9'h1) || buffer_full_flag;
  endproperty
  a_bump: assert property (p_bump)
    else $error("buffer counter not advanced");
  property p_spacing;
    buf_we |=> (!buf_we) [*6];
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("byte writes too close");
  property p_we_ctx;
    buf_we |-> sync_byte_found && read_gate && clock_select == 2'h2;
  endproperty
  a_we_ctx: assert property (p_we_ctx)
    else $error("byte stored outside synced read");
  property p_sync;
    $rose(sync_byte_found) |-> read_gate && !write_gate && clock_select == 2'h2;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync found outside read");
  property p_irq;
    $rose(bus_request_level5) |-> !port_transfer_request && !write_gate
      && clock_select == 2'h0;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt while not idle");
  property p_req_clk;
    $rose(port_transfer_request) |-> clock_select == 2'h0 && !write_gate;
  endproperty
  a_req_clk: assert property (p_req_clk)
    else $error("request raised off cpu clock");
endmodule
bind dsts_seq dsts_chk u_chk (.clk, .rst, .transfer_grant, .port_transfer_request,
  .bus_request_level5, .read_gate, .write_gate, .drive_write_data, .clock_select,
  .sync_byte_found, .buf_select, .buf_addr, .buf_we, .buffer_full_flag);
`default_nettype wire

/* tb/dsts_drive.sv */
// drive side model: servo and read clocks, write capture, read replay
`timescale 1ns/1ps
`default_nettype none
module dsts_drive (
  output logic servo_clk, // free running servo clock
  output logic rd_clk, // read clock, runs only with read gate up
  output logic rd_dat, // serial read data
  input wire logic wr_gate, // write gate from block
  input wire logic rd_gate, // read gate from block
  input wire logic wr_dat // serial write data from block
);
  logic rec[$];
  int idx;
  initial begin
    servo_clk = 1'b0;
    forever #24 servo_clk = ~servo_clk;
  end
  // the block moves its data just after the rising tick, so mid period it is settled
  always @(negedge servo_clk) begin
    if (wr_gate === 1'b1) rec.push_back(wr_dat);
  end
  // replay the captured sector; off the gate the line wanders so no stale level is seen
  initial begin
    rd_clk = 1'b0;
    rd_dat = 1'b0;
    forever begin
      while (rd_gate !== 1'b1) #24 rd_dat = ~rd_dat;
      idx = 0;
      while (rd_gate === 1'b1) begin
        rd_dat = (idx < rec.size()) ? rec[idx] : ~rd_dat;
        idx++;
        #24 rd_clk = 1'b1;
        #24 rd_clk = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the sector transfer sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dsts_pkg::*;
  logic clk, rst, en, reg_wr, reg_rd, transfer_grant, drive_ready, buffer_full_in;
  logic port_transfer_request, bus_request_level5, read_gate, write_gate, write_encoder_enable;
  logic drive_write_data, shift_out_bit, sync_byte_found, buf_select, buf_we, buffer_full_flag;
  logic timer_restart, drive_servo_clock, drive_read_clock, drive_read_data, s;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, st;
  logic [1:0] clock_select, ecc_status;
  logic [8:0] buf_addr;
  logic [7:0] buf_wdata, b;
  logic [15:0] disk_address;
  int err_count, n_tests, nrx, ntr, i;
  function automatic logic [7:0] pat(input logic sl, input logic [8:0] a);
    return a[7:0] ^ (sl ? 8'hc3 : 8'h3c) ^ {7'h0, a[8]};
  endfunction
  wire logic [7:0] buf_rdata = pat(buf_select, buf_addr);
  dsts_drive u_drv (.servo_clk(drive_servo_clock), .rd_clk(drive_read_clock),
    .rd_dat(drive_read_data), .wr_gate(write_gate), .rd_gate(read_gate),
    .wr_dat(drive_write_data));
  dsts_seq dut (.clk, .rst, .en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .transfer_grant, .port_transfer_request, .bus_request_level5, .drive_servo_clock,
    .drive_read_clock, .drive_read_data, .drive_ready, .read_gate, .write_gate,
    .write_encoder_enable, .drive_write_data, .shift_out_bit, .clock_select,
    .sync_byte_found, .buffer_full_in, .buf_rdata, .buf_select, .buf_addr, .buf_wdata,
    .buf_we, .buffer_full_flag, .disk_address, .timer_restart, .ecc_status);
  always #2 clk = ~clk;
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic end_of_test;
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic grant;
    @(posedge clk);
    transfer_grant <= 1'b1;
    @(posedge clk);
    transfer_grant <= 1'b0;
    #1;
  endtask
  // waits on the interrupt when irq is set, else on the transfer request
  task automatic wait_on(input logic irq, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(posedge clk);
      #1;
      if ((irq ? bus_request_level5 : port_transfer_request) === 1'b1) return;
    end
    chk("wait limit", 32'h0, 32'h1);
    end_of_test;
  endtask
  // read bytes come back from buffer A content, one per eight bits
  always @(posedge clk) begin
    if (buf_we === 1'b1) begin
      chk("rx byte", {15'h0, nrx[8:0], pat(1'b0, nrx[8:0])}, {15'h0, buf_addr, buf_wdata});
      nrx++;
    end
    if (timer_restart === 1'b1) ntr++;
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    rd(OFF_STAT, st);
    chk("status reset", 32'h0, st);
    wr(4'h8, 32'hffffffff);
    wr(OFF_STAT, 32'hff);
    rd(4'h8, st);
    chk("unmapped", 32'h0, st);
    rd(OFF_STAT, st);
    chk("status ro", 32'h0, st);
  endtask
  task automatic t_write;
    buffer_full_in <= 1'b1;
    wr(OFF_CTRL, 32'h2);
    wait_on(1'b0, 60000);
    chk("frame bits", 32'h10b0, u_drv.rec.size());
    // ecc bits are not predicted here; the read replay judges them
    for (i = 0; i < 4272 && u_drv.rec.size() == 4272; i++) begin
      if (i < 120 || i >= 4256) b = 8'h0;
      else if (i < 128) b = SYNC_BYTE;
      else if (i < 4224) b = pat(1'b0, 9'((i - 128) / 8));
      else continue;
      chk("write bit", {31'h0, b[i % 8]}, {31'h0, u_drv.rec[i]});
    end
    chk("after write", {20'h0, 1'b0, CK_CPU, 9'h0}, {20'h0, write_gate, clock_select, buf_addr});
  endtask
  task automatic t_next;
    s = buf_select;
    buffer_full_in <= 1'b0;
    grant;
    chk("request", 32'h0, {31'h0, port_transfer_request});
    wait_on(1'b1, 100);
    rd(OFF_STAT, st);
    chk("next sector", {13'h0, ~s, 16'h1, 2'h3}, {13'h0, buf_select, disk_address, st[1:0]});
    chk("timer restart", 32'h1, ntr);
  endtask
  task automatic t_late;
    buffer_full_in <= 1'b1;
    wr(OFF_CTRL, 32'h6);
    wait_on(1'b1, 100);
    rd(OFF_STAT, st);
    chk("read late", 32'h3, {29'h0, st[2:0]});
  endtask
  task automatic t_read;
    buffer_full_in <= 1'b0;
    nrx = 0;
    wr(OFF_CTRL, 32'h6);
    wait_on(1'b0, 60000);
    chk("bytes in", 32'h200, nrx);
    chk("read end", {19'h0, 2'h0, CK_CPU, 9'h0}, {19'h0, ecc_status, clock_select, buf_addr});
    s = buf_select;
    wr(OFF_CTRL, 32'h3);
    grant;
    wait_on(1'b1, 100);
    rd(OFF_STAT, st);
    chk("finish", {30'h0, ~s, 1'b1}, {30'h0, buf_select, st[0]});
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    en = 1'b1;
    drive_ready = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    transfer_grant = 1'b0;
    buffer_full_in = 1'b0;
    err_count = 0;
    n_tests = 0;
    nrx = 0;
    ntr = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_write;
    t_next;
    t_late;
    t_read;
    end_of_test;
  end
endmodule
`default_nettype wire
